/* File: tb/sghc_front_model.sv */
// behavioural detector front end: avalanche sensing, quench done
// assumes the controller clock; bench commands photon arrivals
`timescale 1ns/1ps
module sghc_front_model (
  // clock
  input wire logic clk_i,
  // controller side
  input wire logic det_en_i,
  input wire logic quench_i,
  // bench commands
  input wire logic photon_i,
  input wire logic [3:0] qdly_i,
  // sensed levels
  output logic aval_o,
  output logic quenched_o
);
  int qcnt = 0; // cycles since quench asked
  initial aval_o = 1'b0;
  initial quenched_o = 1'b0;
  // an unbiased detector cannot fire; avalanche ends once quenched
  always @(posedge clk_i) begin
    if (photon_i && det_en_i) aval_o <= 1'b1;
    else if (quenched_o) aval_o <= 1'b0;
  end
  // quench finishes after a commanded delay, prompt or slow
  always @(posedge clk_i) begin
    qcnt <= quench_i ? qcnt + 1 : 0;
    quenched_o <= quench_i && (qcnt >= qdly_i);
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the gate and hold-off controller
// assumes the front-end model and design files compile first
`timescale 1ns/1ps
`include "sghc_defs.svh"
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, fire = 1'b0;
  logic [3:0] addr = 4'h0, qdly = 4'h1;
  logic [7:0] tlev = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, seed = 32'hC8A5E57C;
  logic aval, qdone, det_en, quench, photon, armed, trig;
  logic [31:0] rst_exp [8] = '{32'h0, 32'h14, 32'h190, 32'hC8, 32'h80,
    32'h0, 32'h0, 32'h0};
  int gw_tab [4] = '{0, 1, 7, 15};
  int err_total = 0, compares = 0, tcnt = 0, shots = 0, n, lo, ph, h;
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  sghc_top DUT (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .AVAL_I(aval), .QUENCHED_I(qdone), .TRIG_LEVEL_I(tlev),
    .DET_EN_O(det_en), .QUENCH_O(quench), .PHOTON_O(photon),
    .ARMED_O(armed), .TRIG_OUT_O(trig));
  sghc_front_model FE (.clk_i(clk), .det_en_i(det_en), .quench_i(quench),
    .photon_i(fire), .qdly_i(qdly), .aval_o(aval), .quenched_o(qdone));
  // tally of trigger output pulses
  always @(posedge clk) if (trig === 1'b1) tcnt <= tcnt + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // zero width still opens a one-cycle gate
  function automatic int gate_exp(input int w);
    return (w == 0) ? 1 : w;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // sample just after the edge so registered outputs have landed
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // length of the next complete armed window
  task automatic arm_run(output int len);
    len = 0;
    for (int i = 0; i < 400 && armed === 1'b1; i++) tick();
    for (int i = 0; i < 400 && armed !== 1'b1; i++) tick();
    for (int i = 0; i < 400 && armed === 1'b1; i++) begin
      tick();
      len++;
    end
  endtask
  // fire one photon at a window start, or once armed when not gated; time the dead span to re-arm
  task automatic shot(input bit gated, output int lo, output int ph);
    lo = 0;
    ph = 0;
    for (int i = 0; i < 400 && gated && armed === 1'b1; i++) tick();
    for (int i = 0; i < 400 && armed !== 1'b1; i++) tick();
    fire <= 1'b1;
    tick();
    fire <= 1'b0;
    for (int i = 0; i < 3000 && !(lo > 0 && armed === 1'b1); i++) begin
      tick();
      if (photon === 1'b1) ph++;
      if (armed !== 1'b1) lo++;
    end
    shots++;
  endtask
  task automatic complete_run();
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard, far past the few thousand cycles needed
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, read-only places, unmapped address
    for (int a = 0; a < 8; a++) begin
      rd_reg(4'(a), d);
      chk(d, rst_exp[a]);
    end
    wr_reg(`SGHC_A_CTRL, 32'h3);
    n = tcnt;
    repeat (64) tick();
    chk(tcnt - n, 0);
    wr_reg(`SGHC_A_PER, 32'h20);
    wr_reg(`SGHC_A_CTRL, 32'h7);
    // the old period must run out before the new one takes hold
    repeat (200) tick();
    n = tcnt;
    repeat (320) tick();
    chk(tcnt - n, 10);
    // gate width corners plus one random width
    seed = lfsr(seed);
    gw_tab[2] = 2 + seed[2:0];
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SGHC_A_GATE, gw_tab[i]);
      arm_run(n);
      arm_run(n);
      chk(n, gate_exp(gw_tab[i]));
    end
    wr_reg(`SGHC_A_GATE, 32'hC);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      h = 10 + seed[4:0];
      qdly <= seed[11:8];
      wr_reg(`SGHC_A_HOLD, h);
      shot(1'b1, lo, ph);
      chk(ph, 2);
      chk(lo >= h, 1);
    end
    // sub-threshold noise never opens a gate, a crossing does
    wr_reg(`SGHC_A_THR, 32'h40);
    wr_reg(`SGHC_A_GATE, 32'h6);
    wr_reg(`SGHC_A_CTRL, 32'h3);
    repeat (80) tick();
    n = tcnt;
    lo = 0;
    repeat (60) begin
      seed = lfsr(seed);
      tlev <= {2'b00, seed[5:0]};
      tick();
      if (armed === 1'b1) lo++;
    end
    chk(lo, 0);
    chk(tcnt - n, 0);
    tlev <= 8'hC0;
    arm_run(n);
    chk(n, 6);
    // free-running with random trigger levels that must not matter
    wr_reg(`SGHC_A_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      h = 10 + seed[4:0];
      qdly <= seed[11:8];
      tlev <= seed[23:16];
      wr_reg(`SGHC_A_HOLD, h);
      shot(1'b0, lo, ph);
      chk(ph, 2);
      chk(lo >= h + 4 && lo <= h + seed[11:8] + 16, 1);
    end
    rd_reg(`SGHC_A_COUNT, d);
    chk(d, shots);
    complete_run();
  end
endmodule

/* File: verilog/sghc_defs.svh */
// constants for the gate and hold-off controller
// assumes inclusion by bare name from design files
`ifndef SGHC_DEFS_SVH
`define SGHC_DEFS_SVH
`define SGHC_CLK_MHZ 200
`define SGHC_CNT_W 24
`define SGHC_THR_W 8
`define SGHC_PULSE_NS 10
`define SGHC_PULSE_CYC ((`SGHC_PULSE_NS * `SGHC_CLK_MHZ + 999) / 1000)
`define SGHC_RESTORE_NS 20
`define SGHC_RESTORE_CYC ((`SGHC_RESTORE_NS * `SGHC_CLK_MHZ + 999) / 1000)
`define SGHC_ADDR_W 4
`define SGHC_A_CTRL 4'h0
`define SGHC_A_GATE 4'h1
`define SGHC_A_HOLD 4'h2
`define SGHC_A_PER 4'h3
`define SGHC_A_THR 4'h4
`define SGHC_A_STAT 4'h5
`define SGHC_A_COUNT 4'h6
`define SGHC_B_EN 0
`define SGHC_B_GATED 1
`define SGHC_B_INTTRIG 2
`define SGHC_GATE_RST 24'h000014
`define SGHC_HOLD_RST 24'h000190
`define SGHC_PER_RST 24'h0000C8
`define SGHC_THR_RST 8'h80
`endif

/* File: verilog/sghc_pkg.sv */
// types for the gate and hold-off controller
// assumes the defs header sits beside it
package sghc_pkg;
  // detector control phases
  typedef enum logic [2:0] {
    SGHC_IDLE = 3'b000,
    SGHC_WAIT = 3'b001,
    SGHC_ARMED = 3'b010,
    SGHC_QUENCH = 3'b011,
    SGHC_HOLD = 3'b100,
    SGHC_RESTORE = 3'b101
  } sghc_state_t;
endpackage

/* File: verilog/sghc_top.sv */
// gate and hold-off controller for an avalanche detector
// assumes synchronous avalanche and trigger inputs, 200 MHz clock
// Notes on behaviour
// - one pulse per avalanche, rising edge marks
// - armed output high while detector enabled
// - armed output low during hold-off
// - trigger output off unless internal trigger chosen
// - trigger output carries internal periodic reference in gated mode with internal trigger chosen
// - triggers only matter with gated head
// - external trigger qualified by programmable threshold
// - gated mode enables detector for gate width
// - hold-off suppresses gates after each avalanche
// - free-running re-arms after quench plus hold-off
// - bias restored before next detection allowed
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "sghc_defs.svh"
module sghc_top
  import sghc_pkg::*;
#(
  parameter int CNT_W = `SGHC_CNT_W,
  parameter int THR_W = `SGHC_THR_W
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // register port
  input wire logic [`SGHC_ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // front end
  input wire logic AVAL_I,
  input wire logic QUENCHED_I,
  input wire logic [THR_W-1:0] TRIG_LEVEL_I,
  output logic DET_EN_O,
  output logic QUENCH_O,
  // panel outputs
  output logic PHOTON_O,
  output logic ARMED_O,
  output logic TRIG_OUT_O
);
  logic rst_s1_reg; // reset synchroniser
  logic rst_n;
  // registers written by software, then the avalanche counter
  logic [2:0] ctrl_reg;
  logic [CNT_W-1:0] gate_width_reg;
  logic [CNT_W-1:0] holdoff_time_reg;
  logic [CNT_W-1:0] period_reg;
  logic [THR_W-1:0] thr_reg;
  logic [31:0] count_reg; // avalanche counter
  // engine state
  sghc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next; // gate/hold/restore timer
  logic [CNT_W-1:0] per_reg; // period timer
  logic [7:0] pulse_reg; // photon pulse timer
  logic ref_reg; // internal periodic reference
  logic ext_ev;
  logic en, gated, int_sel, gate_ev, tick, aval_ev;
  logic [31:0] rdata_next;

  // reset released through two flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // decode of control bits
  assign en = ctrl_reg[`SGHC_B_EN];
  assign gated = ctrl_reg[`SGHC_B_GATED];
  assign int_sel = ctrl_reg[`SGHC_B_INTTRIG];
  assign tick = (per_reg == '0);
  // triggers count only for a gated head
  assign gate_ev = gated & (int_sel ? tick : ext_ev);
  assign aval_ev = AVAL_I & (state_reg == SGHC_ARMED);

  sghc_trig_qual #(.THR_W(THR_W)) u_qual (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .level_i(TRIG_LEVEL_I),
    .thr_i(thr_reg),
    .event_o(ext_ev)
  );

  // function: load value minus one, floored at zero
  function automatic logic [CNT_W-1:0] load_of(input logic [CNT_W-1:0] v);
    load_of = (v == '0) ? '0 : v - 1'b1;
  endfunction

  // register writes
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 3'h0;
      gate_width_reg <= CNT_W'(`SGHC_GATE_RST);
      holdoff_time_reg <= CNT_W'(`SGHC_HOLD_RST);
      period_reg <= CNT_W'(`SGHC_PER_RST);
      thr_reg <= THR_W'(`SGHC_THR_RST);
    end else if (WR_I) begin
      case (ADDR_I)
        `SGHC_A_CTRL: ctrl_reg <= WDATA_I[2:0];
        `SGHC_A_GATE: gate_width_reg <= WDATA_I[CNT_W-1:0];
        `SGHC_A_HOLD: holdoff_time_reg <= WDATA_I[CNT_W-1:0];
        `SGHC_A_PER: period_reg <= WDATA_I[CNT_W-1:0];
        `SGHC_A_THR: thr_reg <= WDATA_I[THR_W-1:0];
        default: ; // unmapped writes ignored
      endcase
    end
  end

  // read mux, data one cycle after strobe; unmapped reads zero
  always_comb begin
    rdata_next = 32'h0;
    unique case (ADDR_I)
      `SGHC_A_CTRL: rdata_next = {29'h0, ctrl_reg};
      `SGHC_A_GATE: rdata_next = 32'(gate_width_reg);
      `SGHC_A_HOLD: rdata_next = 32'(holdoff_time_reg);
      `SGHC_A_PER: rdata_next = 32'(period_reg);
      `SGHC_A_THR: rdata_next = 32'(thr_reg);
      `SGHC_A_STAT: rdata_next = {29'h0, state_reg};
      `SGHC_A_COUNT: rdata_next = count_reg;
      default: rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) RDATA_O <= 32'h0;
    else RDATA_O <= RD_I ? rdata_next : 32'h0;
  end

  // internal periodic reference generator
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      per_reg <= '0;
      ref_reg <= 1'b0;
    end else begin
      per_reg <= tick ? load_of(period_reg) : per_reg - 1'b1;
      ref_reg <= tick;
    end
  end

  // detector phase sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg == '0) ? '0 : cnt_reg - 1'b1;
    unique case (state_reg)
      SGHC_IDLE: begin
        if (en) state_next = gated ? SGHC_WAIT : SGHC_ARMED;
      end
      SGHC_WAIT: begin
        if (!en) state_next = SGHC_IDLE;
        // mode switched to free-running: no gate will ever come
        else if (!gated) state_next = SGHC_ARMED;
        else if (gate_ev) begin
          state_next = SGHC_ARMED;
          cnt_next = load_of(gate_width_reg);
        end
      end
      SGHC_ARMED: begin
        if (!en) state_next = SGHC_IDLE;
        else if (AVAL_I) state_next = SGHC_QUENCH;
        else if (gated && cnt_reg == '0) state_next = SGHC_WAIT;
      end
      SGHC_QUENCH: begin
        if (QUENCHED_I) begin
          state_next = SGHC_HOLD;
          cnt_next = load_of(holdoff_time_reg);
        end
      end
      SGHC_HOLD: begin
        // gates arriving now are skipped
        if (cnt_reg == '0) begin
          state_next = SGHC_RESTORE;
          cnt_next = CNT_W'(`SGHC_RESTORE_CYC - 1);
        end
      end
      SGHC_RESTORE: begin
        // bias recovers; no detection reported
        if (cnt_reg == '0) begin
          if (!en) state_next = SGHC_IDLE;
          else state_next = gated ? SGHC_WAIT : SGHC_ARMED;
        end
      end
      default: state_next = SGHC_IDLE;
    endcase
  end

  // state, counters and registered outputs
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SGHC_IDLE;
      cnt_reg <= '0;
      pulse_reg <= 8'h0;
      count_reg <= 32'h0;
      DET_EN_O <= 1'b0;
      QUENCH_O <= 1'b0;
      PHOTON_O <= 1'b0;
      ARMED_O <= 1'b0;
      TRIG_OUT_O <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (aval_ev) pulse_reg <= 8'(`SGHC_PULSE_CYC);
      else if (pulse_reg != 8'h0) pulse_reg <= pulse_reg - 8'h01;
      if (aval_ev) count_reg <= count_reg + 32'h1;
      PHOTON_O <= aval_ev | (pulse_reg > 8'h1);
      DET_EN_O <= (state_next == SGHC_ARMED);
      QUENCH_O <= (state_next == SGHC_QUENCH);
      ARMED_O <= (state_next == SGHC_ARMED);
      TRIG_OUT_O <= gated & int_sel & ref_reg;
    end
  end

  // checks
  property p_armed_tracks;
    @(posedge CLK_I) disable iff (!rst_n)
      1'b1 |=> (ARMED_O == ($past(state_next) == SGHC_ARMED));
  endproperty
  a_armed_tracks: assert property (p_armed_tracks)
    else $error("armed output disagrees with state");
  property p_hold_low;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_HOLD) |-> !ARMED_O;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("armed high during hold-off");
  property p_trig_off;
    @(posedge CLK_I) disable iff (!rst_n)
      !$past(int_sel) |-> !TRIG_OUT_O;
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("trigger out active without internal select");
  property p_photon;
    @(posedge CLK_I) disable iff (!rst_n)
      aval_ev |=> PHOTON_O ##1 PHOTON_O;
  endproperty
  a_photon: assert property (p_photon)
    else $error("photon pulse missing after avalanche");
  property p_hold_to_restore;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_HOLD && cnt_reg == '0) |=>
        state_reg == SGHC_RESTORE;
  endproperty
  a_hold_to_restore: assert property (p_hold_to_restore)
    else $error("hold-off expiry not followed by restore");
  sequence s_restore_end;
    state_reg == SGHC_RESTORE && cnt_reg == '0;
  endsequence
  property p_no_detect_restore;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_RESTORE) |-> !DET_EN_O;
  endproperty
  a_no_detect_restore: assert property (p_no_detect_restore)
    else $error("detector enabled while bias restores");
  property p_free_rearm;
    @(posedge CLK_I) disable iff (!rst_n)
      (s_restore_end and (en && !gated)) |=> state_reg == SGHC_ARMED;
  endproperty
  a_free_rearm: assert property (p_free_rearm)
    else $error("free-running did not re-arm");
  property p_gate_close;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_ARMED && gated && en && !AVAL_I
       && cnt_reg == '0) |=> state_reg == SGHC_WAIT;
  endproperty
  a_gate_close: assert property (p_gate_close)
    else $error("gate window did not close");
  // a gate event while waiting opens the window on the next cycle
  property p_gate_open;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_WAIT && en && gate_ev) |=> ARMED_O;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("gate event did not open a window");
  // selected reference pulse reaches the pin one cycle later
  property p_trig_follows_ref;
    @(posedge CLK_I) disable iff (!rst_n)
      (ref_reg && gated && int_sel) |=> TRIG_OUT_O;
  endproperty
  a_trig_follows_ref: assert property (p_trig_follows_ref)
    else $error("trigger out missed a reference pulse");
  // an upward crossing of the threshold yields a trigger event
  property p_cross_event;
    @(posedge CLK_I) disable iff (!rst_n)
      (TRIG_LEVEL_I >= thr_reg && !$past(TRIG_LEVEL_I >= thr_reg))
        |=> ext_ev;
  endproperty
  a_cross_event: assert property (p_cross_event)
    else $error("threshold crossing gave no trigger event");
  // hold-off timer starts from the programmed count less one after quench
  property p_hold_load;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_QUENCH && QUENCHED_I && holdoff_time_reg != '0)
        |=> cnt_reg == $past(holdoff_time_reg) - 1'b1;
  endproperty
  a_hold_load: assert property (p_hold_load)
    else $error("hold-off timer not loaded from its setting");
  // a free-running head never waits on trigger events
  property p_free_no_gate;
    @(posedge CLK_I) disable iff (!rst_n)
      (state_reg == SGHC_WAIT && en && !gated) |=> state_reg == SGHC_ARMED;
  endproperty
  a_free_no_gate: assert property (p_free_no_gate)
    else $error("free-running head left waiting for a gate");
endmodule

/* File: verilog/sghc_trig_qual.sv */
// trigger threshold qualifier: edge of sampled level over threshold
// assumes trigger samples synchronous to the clock
`timescale 1ns/1ps
`include "sghc_defs.svh"
module sghc_trig_qual #(
  parameter int THR_W = `SGHC_THR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // sample and threshold
  input wire logic [THR_W-1:0] level_i,
  input wire logic [THR_W-1:0] thr_i,
  // one-cycle crossing event
  output logic event_o
);
  logic above_reg; // last comparison
  logic above_now;
  assign above_now = (level_i >= thr_i);
  // rising crossing of threshold gives one event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      above_reg <= 1'b0;
      event_o <= 1'b0;
    end else begin
      above_reg <= above_now;
      event_o <= above_now & ~above_reg;
    end
  end
endmodule
